// ### core/lvd_fifo.sv
`timescale 1ns/10ps
module lvd_fifo #(
    parameter int WIDTH = lvd_pkg::FIFO_W,
    parameter int DEPTH = lvd_pkg::FIFO_D
) (
    // Clock and synchronised reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Both sides of the queue
    lvd_fifo_if.store f
);
    import lvd_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    // Handshake terms; full and empty straight from the count
    assign f.wr_ready = (count_reg != (PTR_W+1)'(DEPTH));
    assign f.rd_valid = (count_reg != '0);
    assign f.rd_data  = mem_reg[rd_ptr_reg];
    assign f.level    = CNT_W'(count_reg);
    assign push       = f.wr_valid && f.wr_ready;
    assign pop        = f.rd_valid && f.rd_ready;

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= f.wr_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // lvd_fifo

// ### core/lvd_fifo_if.sv
`timescale 1ns/10ps
interface lvd_fifo_if;
    import lvd_pkg::*;

    logic              wr_valid;
    logic              wr_ready;
    logic [FIFO_W-1:0] wr_data;
    logic              rd_valid;
    logic              rd_ready;
    logic [FIFO_W-1:0] rd_data;
    logic [CNT_W-1:0]  level;

    // Storage side
    modport store (
        input  wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data, level
    );

    // User side
    modport user (
        output wr_valid, wr_data, rd_ready,
        input  wr_ready, rd_valid, rd_data, level
    );

endinterface // lvd_fifo_if

// ### core/lvd_insel.sv
`timescale 1ns/10ps
module lvd_insel (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    // AHB-Lite slave
    input  wire logic                         hsel_i,
    input  wire logic [31:0]                  haddr_i,
    input  wire logic [1:0]                   htrans_i,
    input  wire logic                         hwrite_i,
    input  wire logic [2:0]                   hsize_i,
    input  wire logic [31:0]                  hwdata_i,
    input  wire logic                         hready_i,
    output logic                              hreadyout_o,
    output logic                              hresp_o,
    output logic [31:0]                       hrdata_o,
    // Parallel sample buses
    input  wire logic [lvd_pkg::SAMPLE_W-1:0] bus_a_i,
    input  wire logic [lvd_pkg::SAMPLE_W-1:0] bus_b_i,
    input  wire logic [lvd_pkg::SAMPLE_W-1:0] bus_c_i,
    input  wire logic [lvd_pkg::SAMPLE_W-1:0] bus_d_i,
    input  wire logic                         in_valid_i,
    output logic                              in_ready_o,
    // Detector side stream
    output logic                              out_valid_o,
    input  wire logic                         out_ready_i,
    output logic [lvd_pkg::FIFO_W-1:0]        out_data_o
);
    import lvd_pkg::*;

    logic                rst_q1_reg;
    logic                rst_n;
    logic [SAMPLE_W-1:0] bus_q1_reg [4];
    logic [SAMPLE_W-1:0] bus_q2_reg [4];
    logic                vld_q1_reg;
    logic                vld_q2_reg;
    logic                ap_wr_reg;
    logic [31:0]         ap_addr_reg;
    logic [31:0]         src_fmt_reg;
    logic [TEST_W-1:0]   test_reg;
    logic                strobe_reg;
    logic [31:0]         hrdata_reg;
    logic                ahb_go;
    logic                test_en;
    logic                use_test;
    logic [2:0]          src;
    logic [SAMPLE_W-1:0] raw;
    logic [4:0]          mant_w;
    logic [MANT_W-1:0]   mant;
    logic [EXP_W-1:0]    expo;
    logic [EXP_W-1:0]    shift;
    logic [SAMPLE_W-1:0] adj;
    lvd_fifo_if          q ();

    // Mantissa width from extended enable, mode bit 2 and size bits
    function automatic logic [4:0] mant_width(input logic [31:0] fmt);
        logic [2:0] code;
        code = {fmt[MODE2_BIT], fmt[MANT_LSB+1], fmt[MANT_LSB]};
        if (fmt[EXT_BIT]) begin
            case (code)
                3'h0:    mant_width = 5'h0b;
                3'h1:    mant_width = 5'h0c;
                3'h2:    mant_width = 5'h0d;
                3'h3:    mant_width = 5'h0e;
                3'h4:    mant_width = 5'h0f;
                3'h5:    mant_width = 5'h10;
                default: mant_width = 5'h0e;
            endcase
        end else begin
            mant_width = 5'h0e - {3'h0, code[1:0]};
        end
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_q1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_q1_reg <= 1'b1;
            rst_n      <= rst_q1_reg;
        end
    end

    // Two-stage synchronisers on the sample pins
    always_ff @(posedge clk_i) begin
        bus_q1_reg[0] <= bus_a_i;
        bus_q1_reg[1] <= bus_b_i;
        bus_q1_reg[2] <= bus_c_i;
        bus_q1_reg[3] <= bus_d_i;
        bus_q2_reg    <= bus_q1_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vld_q1_reg <= 1'b0;
            vld_q2_reg <= 1'b0;
        end else begin
            vld_q1_reg <= in_valid_i;
            vld_q2_reg <= vld_q1_reg;
        end
    end

    // Bus address phase capture; zero wait state, always OKAY
    assign ahb_go      = hsel_i && htrans_i[HTRANS_ACT] && hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr_reg   <= 1'b0;
            ap_addr_reg <= '0;
        end else begin
            ap_wr_reg   <= ahb_go && hwrite_i;
            ap_addr_reg <= haddr_i;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_fmt_reg <= SRC_FMT_RST;
            test_reg    <= TEST_RST;
        end else if (ap_wr_reg) begin
            if (ap_addr_reg == ADDR_SRC_FMT) begin
                src_fmt_reg <= hwdata_i & SRC_FMT_MASK;
            end
            if (ap_addr_reg == ADDR_TEST) begin
                test_reg <= hwdata_i[TEST_W-1:0];
            end
        end
    end

    // One-clock test enable pulse on each strobe write
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= ap_wr_reg && (ap_addr_reg == ADDR_STROBE);
        end
    end

    // Read data prepared from the address phase
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_reg <= '0;
        end else if (ahb_go && !hwrite_i) begin
            case (haddr_i)
                ADDR_SRC_FMT: hrdata_reg <= src_fmt_reg;
                ADDR_STATUS: begin
                    hrdata_reg <= '0;
                    hrdata_reg[STAT_LVL_LSB +: CNT_W] <= q.level;
                    hrdata_reg[STAT_RDY_BIT] <= q.wr_ready;
                end
                default:      hrdata_reg <= '0;
            endcase
        end
    end

    // Test enable: inverted level of bit 11 or the strobe pulse
    assign test_en = src_fmt_reg[TSEL_BIT] ? !src_fmt_reg[TEN_BIT]
                                           : strobe_reg;

    // Source routing
    assign src      = src_fmt_reg[SRC_LSB +: 3];
    assign use_test = (src > SRC_BUS_D);
    assign raw      = use_test ? {1'b0, test_reg}
                               : bus_q2_reg[src[1:0]];

    // Format conversion to sign-extended mantissa and shift code
    assign mant_w = src_fmt_reg[FLT_BIT] ? mant_width(src_fmt_reg)
                                         : 5'h10;

    always_comb begin
        adj  = raw;
        mant = '0;
        expo = '0;
        if (src_fmt_reg[OFS_BIT]) begin
            adj[mant_w - 5'h1] = ~raw[mant_w - 5'h1];
        end
        for (int i = 0; i < MANT_W; i++) begin
            mant[i] = (i < int'(mant_w)) ? adj[i]
                                         : adj[mant_w - 5'h1];
        end
        if (src_fmt_reg[FLT_BIT]) begin
            for (int j = 0; j < EXP_W; j++) begin
                if (int'(mant_w) + j < SAMPLE_W) begin
                    expo[j] = adj[int'(mant_w) + j];
                end
            end
        end
    end

    assign shift = expo + ~src_fmt_reg[SAT_LSB +: 3];

    // Queue towards the detector; ready stalls the source
    assign q.wr_valid  = use_test ? test_en : vld_q2_reg;
    assign q.wr_data   = {shift, mant};
    assign q.rd_ready  = out_ready_i;
    assign in_ready_o  = q.wr_ready;
    assign out_valid_o = q.rd_valid;
    assign out_data_o  = q.rd_data;

    lvd_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_b_i (rst_n),
        .f       (q)
    );

    // Checks on the data path and register effects
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    src_bus_a: assert property (
        src < 3'h4 |-> raw == bus_q2_reg[src[1:0]])
        else $error("bus source not routed");

    src_test_a: assert property (
        src > 3'h3 |-> raw == {1'b0, test_reg})
        else $error("test source not routed");

    test_write_a: assert property (
        ap_wr_reg && ap_addr_reg == ADDR_TEST ##1 src > 3'h3
        |-> raw[TEST_W-1:0] == $past(hwdata_i[TEST_W-1:0]))
        else $error("test register write lost");

    strobe_pulse_a: assert property (
        ap_wr_reg && ap_addr_reg == ADDR_STROBE && !src_fmt_reg[TSEL_BIT]
        |=> test_en ##1 !test_en || strobe_reg)
        else $error("strobe pulse wrong");

    test_level_a: assert property (
        src_fmt_reg[TSEL_BIT] |-> test_en != src_fmt_reg[TEN_BIT])
        else $error("test enable level wrong");

    offset_fix_a: assert property (
        !src_fmt_reg[FLT_BIT] |-> mant[MANT_W-1] ==
        (raw[MANT_W-1] ^ src_fmt_reg[OFS_BIT]))
        else $error("sign bit conversion wrong");

    shift_code_a: assert property (
        !src_fmt_reg[FLT_BIT] && src_fmt_reg[SAT_LSB +: 3] == 3'h0
        |-> shift == 3'h7)
        else $error("fixed point shift code wrong");

    ext_width_a: assert property (
        src_fmt_reg[FLT_BIT] && src_fmt_reg[EXT_BIT] && src_fmt_reg[MODE2_BIT]
        && src_fmt_reg[MANT_LSB +: 2] == 2'h1
        |-> mant_w == 5'h10 && expo == {2'h0, adj[16]})
        else $error("16 bit extended split wrong");

    float_split_a: assert property (
        src_fmt_reg[FLT_BIT] && mant_w == 5'h0b
        |-> mant[15:10] == {6{adj[10]}} && expo == adj[13:11])
        else $error("11 bit split wrong");

    full_stall_a: assert property (
        q.level == 5'h10 && !q.rd_ready
        |-> !in_ready_o ##1 q.level == 5'h10)
        else $error("full queue accepted data");

    // Offset binary in the 14 bit float format flips the mantissa top bit
    float_ofs_a: assert property (
        src_fmt_reg[FLT_BIT] && src_fmt_reg[OFS_BIT] && mant_w == 5'h0e
        |-> mant[13] == !raw[13] && mant[15:14] == {2{!raw[13]}})
        else $error("float offset sign wrong");

    cover_pulse_c: cover property (strobe_reg && q.wr_valid && use_test);
    cover_full_c:  cover property (q.level == 5'h10);
    cover_ext_c:   cover property (src_fmt_reg[EXT_BIT] && q.wr_valid);
    cover_ofs_c:   cover property (src_fmt_reg[OFS_BIT] && q.wr_valid);

endmodule // lvd_insel

// ### core/lvd_pkg.sv
package lvd_pkg;

    // Widths of the data path
    localparam int SAMPLE_W = 17;
    localparam int TEST_W   = 16;
    localparam int MANT_W   = 16;
    localparam int EXP_W    = 3;
    localparam int FIFO_W   = EXP_W + MANT_W;
    localparam int FIFO_D   = 16;
    localparam int CNT_W    = 5;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_SRC_FMT = 16'hf804;
    localparam logic [15:0] IDX_TEST    = 16'hf807;
    localparam logic [15:0] IDX_STROBE  = 16'hf808;
    localparam logic [15:0] IDX_STATUS  = 16'hf809;
    localparam logic [31:0] ADDR_SRC_FMT = {14'h0, IDX_SRC_FMT, 2'h0};
    localparam logic [31:0] ADDR_TEST    = {14'h0, IDX_TEST, 2'h0};
    localparam logic [31:0] ADDR_STROBE  = {14'h0, IDX_STROBE, 2'h0};
    localparam logic [31:0] ADDR_STATUS  = {14'h0, IDX_STATUS, 2'h0};

    // Reset values and writable bits
    localparam logic [31:0] SRC_FMT_RST  = 32'h0000_0000;
    localparam logic [31:0] SRC_FMT_MASK = 32'h01ff_ffff;
    localparam logic [15:0] TEST_RST     = 16'h0000;

    // Field positions of the source/format register
    localparam int SAT_LSB   = 18;
    localparam int EXT_BIT   = 17;
    localparam int MODE2_BIT = 16;
    localparam int SRC_LSB   = 13;
    localparam int TSEL_BIT  = 12;
    localparam int TEN_BIT   = 11;
    localparam int OFS_BIT   = 10;
    localparam int FLT_BIT   = 9;
    localparam int MANT_LSB  = 7;

    // Source select codes
    localparam logic [2:0] SRC_BUS_A = 3'h0;
    localparam logic [2:0] SRC_BUS_D = 3'h3;

    // Status register fields
    localparam int STAT_LVL_LSB = 0;
    localparam int STAT_RDY_BIT = 8;

    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACT = 1;

endpackage

// ### tb/lvd_src_model.sv
`timescale 1ns/10ps
module lvd_src_model (
    // Clock
    input  wire logic                    clk_i,
    // Sample buses and their valid
    output logic [lvd_pkg::SAMPLE_W-1:0] bus_a_o,
    output logic [lvd_pkg::SAMPLE_W-1:0] bus_b_o,
    output logic [lvd_pkg::SAMPLE_W-1:0] bus_c_o,
    output logic [lvd_pkg::SAMPLE_W-1:0] bus_d_o,
    output logic                         valid_o
);
    import lvd_pkg::*;

    // Idle buses at time zero
    initial begin
        bus_a_o = '0;
        bus_b_o = '0;
        bus_c_o = '0;
        bus_d_o = '0;
        valid_o = 1'b0;
    end

    // One sample on all 17 lines of every bus, held past the sync flops
    task automatic send(input logic [SAMPLE_W-1:0] a, b, c, d);
        @(posedge clk_i);
        bus_a_o <= a;
        bus_b_o <= b;
        bus_c_o <= c;
        bus_d_o <= d;
        valid_o <= 1'b1;
        @(posedge clk_i);
        valid_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        // Released lines show the inverse of the last word
        bus_a_o <= ~a;
        bus_b_o <= ~b;
        bus_c_o <= ~c;
        bus_d_o <= ~d;
    endtask
endmodule // lvd_src_model

// ### tb/test_level_detector_input_select.sv
`timescale 1ns/10ps
module test_level_detector_input_select;
    import lvd_pkg::*;

    localparam logic [31:0] F_EXT = 32'h1 << EXT_BIT;
    localparam logic [31:0] F_M2  = 32'h1 << MODE2_BIT;
    localparam logic [31:0] F_TS  = 32'h1 << TSEL_BIT;
    localparam logic [31:0] F_TEN = 32'h1 << TEN_BIT;
    localparam logic [31:0] F_OFS = 32'h1 << OFS_BIT;
    localparam logic [31:0] F_FLT = 32'h1 << FLT_BIT;
    localparam logic [31:0] F_M0  = 32'h1 << MANT_LSB;

    logic                clk, rst_b, hsel, hwrite, hready, hresp;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr, hwdata, hrdata;
    logic [SAMPLE_W-1:0] ba, bb, bc, bd;
    logic                in_valid, in_ready, out_valid, out_ready;
    logic [FIFO_W-1:0]   out_data;
    int                  err_count, checked;

    lvd_insel i_dut (.clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .bus_a_i(ba), .bus_b_i(bb), .bus_c_i(bc), .bus_d_i(bd),
        .in_valid_i(in_valid), .in_ready_o(in_ready),
        .out_valid_o(out_valid), .out_ready_i(out_ready),
        .out_data_o(out_data));

    lvd_src_model i_src (.clk_i(clk), .bus_a_o(ba), .bus_b_o(bb),
        .bus_c_o(bc), .bus_d_o(bd), .valid_o(in_valid));

    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Verdict and end of run
    task automatic complete_run;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A wait that ran out
    task automatic hang;
        err_count++;
        complete_run;
    endtask

    // Compare and report
    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) hang;
        end while (hready !== 1'b1);
    endtask

    // Single AHB-Lite word transfer
    task automatic xfer(input logic w, input logic [31:0] a, wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, wd);
        logic [31:0] x;
        xfer(1'b1, a, wd, x);
    endtask

    task automatic rd_chk(input logic [31:0] a, exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(x, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Take the head word from the queue and compare it
    task automatic get_word(input logic [FIFO_W-1:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n > 50) hang;
        end while (out_valid !== 1'b1);
        chk({13'h0, out_data}, {13'h0, exp});
        @(posedge clk);
        out_ready <= 1'b1;
        @(posedge clk);
        out_ready <= 1'b0;
    endtask

    function automatic logic [31:0] fmt(input logic [2:0] src, sat,
                                        input logic [31:0] bits);
        fmt = (32'(src) << SRC_LSB) | (32'(sat) << SAT_LSB) | bits;
    endfunction

    // Reset values, unmapped and write-only reads, masked bits
    task automatic t_regs;
        rd_chk(ADDR_SRC_FMT, SRC_FMT_RST);
        rd_chk(ADDR_STATUS, 32'h100);
        rd_chk(ADDR_TEST, 32'h0);
        rd_chk(32'h100, 32'h0);
        wr(ADDR_SRC_FMT, 32'hfe1f_ffff);
        rd_chk(ADDR_SRC_FMT, 32'h001f_ffff);
        wr(ADDR_SRC_FMT, 32'h0);
    endtask

    // Buses A to D in fixed two's complement, then bus B in offset binary
    task automatic t_sources;
        logic [SAMPLE_W-1:0] v [4];
        v = '{17'h1_1111, 17'h0_2222, 17'h1_3333, 17'h0_8444};
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_SRC_FMT, fmt(3'(s), 3'h0, 32'h0));
            i_src.send(v[0], v[1], v[2], v[3]);
            get_word({3'h7, v[s][15:0]});
        end
        wr(ADDR_SRC_FMT, fmt(3'h1, 3'h0, F_OFS));
        i_src.send(17'h0_0aaa, 17'h0_0123, 17'h0_0bbb, 17'h0_0ccc);
        get_word({3'h7, 16'h8123});
    endtask

    // Floating point splits and shift code
    task automatic t_float;
        wr(ADDR_SRC_FMT, fmt(3'h0, 3'h5, F_FLT));
        i_src.send(17'h1_6abc, 17'h0, 17'h0, 17'h0);
        get_word({3'h7, 16'heabc});
        wr(ADDR_SRC_FMT, fmt(3'h0, 3'h0, F_EXT | F_M2 | F_FLT | F_M0));
        i_src.send(17'h1_8001, 17'h0, 17'h0, 17'h0);
        get_word({3'h0, 16'h8001});
        wr(ADDR_SRC_FMT, fmt(3'h0, 3'h5, F_FLT | F_M0 | (F_M0 << 1)));
        i_src.send(17'h0_2c05, 17'h0, 17'h0, 17'h0);
        get_word({3'h7, 16'hfc05});
    endtask

    // Test register words queued by strobe writes
    task automatic t_strobe;
        logic [2:0] c [2];
        c = '{3'h4, 3'h7};
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_SRC_FMT, fmt(c[i], 3'h0, 32'h0));
            wr(ADDR_TEST, 32'h1230 + 32'(i));
            wr(ADDR_STROBE, 32'h0);
            get_word({3'h7, 16'h1230 + 16'(i)});
            rd_chk(ADDR_STATUS, 32'h100);
        end
    endtask

    // Continuous test enable fills the queue, then drain it
    task automatic t_fill;
        int n;
        wr(ADDR_TEST, 32'h0055);
        wr(ADDR_SRC_FMT, fmt(3'h4, 3'h0, F_TS | F_TEN));
        repeat (4) @(posedge clk);
        rd_chk(ADDR_STATUS, 32'h100);
        wr(ADDR_SRC_FMT, fmt(3'h4, 3'h0, F_TS));
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n > 50) hang;
        end while (in_ready !== 1'b0);
        rd_chk(ADDR_STATUS, 32'h010);
        wr(ADDR_SRC_FMT, fmt(3'h4, 3'h0, F_TS | F_TEN));
        for (int i = 0; i < FIFO_D; i++) get_word({3'h7, 16'h0055});
        rd_chk(ADDR_STATUS, 32'h100);
        chk({31'h0, out_valid}, 32'h0);
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        checked   = 0;
        rst_b     = 1'b0;
        hsel      = 1'b0;
        htrans    = 2'h0;
        haddr     = 32'h0;
        hwrite    = 1'b0;
        hsize     = 3'h2;
        hwdata    = 32'h0;
        out_ready = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_sources;
        t_float;
        t_strobe;
        t_fill;
        complete_run;
    end
endmodule // test_level_detector_input_select
